// ### src/spg_gpio.sv
// Shared-pin general-purpose ports E, F and G with their Wishbone registers.
// Assumes the SPI, serial, timer and keyboard units sit beside this block and
// hand in their enable bits and pin drive; they read pins from the sync outputs.
//
// Local design decision: the Wishbone interface to the registers.
`timescale 1ns/1ps
`default_nettype none

module spg_gpio
	import spg_pkg::*;
(
	input wire logic clk_i,
	input wire logic rst_i,
	// Wishbone classic slave.
	input wire logic cyc_i,
	input wire logic stb_i,
	input wire logic we_i,
	input wire logic [ADR_W-1:0] adr_i,
	input wire logic [3:0] sel_i,
	input wire logic [DAT_W-1:0] dat_i,
	output logic [DAT_W-1:0] dat_o,
	output logic ack_o,
	// Pins, three signals each.
	input wire logic [E_W-1:0] pin_e_i,
	output logic [E_W-1:0] pin_e_o,
	output logic [E_W-1:0] pin_e_oe_o,
	input wire logic [F_W-1:0] pin_f_i,
	output logic [F_W-1:0] pin_f_o,
	output logic [F_W-1:0] pin_f_oe_o,
	input wire logic [G_W-1:0] pin_g_i,
	output logic [G_W-1:0] pin_g_o,
	output logic [G_W-1:0] pin_g_oe_o,
	// Filtered pin levels for the borrowing peripherals.
	output logic [E_W-1:0] pin_e_sync_o,
	output logic [F_W-1:0] pin_f_sync_o,
	output logic [G_W-1:0] pin_g_sync_o,
	// SPI controls and drive.
	input wire logic spi_enable_bit_i,
	input wire logic spi_master_select_bit_i,
	input wire logic mode_fault_enable_bit_i,
	input wire logic spi_serial_clock_pin_i,
	input wire logic spi_mosi_out_i,
	input wire logic spi_miso_out_i,
	// Serial interface.
	input wire logic serial_enable_bit_i,
	input wire logic serial_txd_i,
	// Timers: two edge/level select bits per channel.
	input wire logic [2*TA_CH-1:0] timer_a_edge_level_select_bits_i,
	input wire logic [TA_CH-1:0] timer_a_channel_pins_out_i,
	input wire logic [TA_CH-1:0] timer_a_channel_pins_oe_i,
	input wire logic [2*TB_CH-1:0] timer_b_edge_level_select_bits_i,
	input wire logic [TB_CH-1:0] timer_b_channel_pins_out_i,
	input wire logic [TB_CH-1:0] timer_b_channel_pins_oe_i,
	// Keyboard interrupt unit.
	input wire logic [G_W-1:0] keyboard_irq_enable_bits_i
);

	// ==========================================================
	// Helper functions.

	// A channel owns its pin whenever its select pair is not 00.
	function automatic logic [7:0] els_owned(input logic [15:0] els);
		logic [7:0] r;
		r = 8'h00;
		for (int i = 0; i < 8; i++) begin
			r[i] = els[2*i] | els[2*i+1];
		end
		return r;
	endfunction

	// Read source: latch where direction is one, pin level where zero.
	function automatic logic [7:0] rd_mux(input logic [7:0] dir, input logic [7:0] lat,
		input logic [7:0] pin);
		return (dir & lat) | (~dir & pin);
	endfunction

	// ==========================================================
	// Registers.
	logic [E_W-1:0] dir_e_q;
	logic [F_W-1:0] dir_f_q;
	logic [G_W-1:0] dir_g_q;
	logic [E_W-1:0] lat_e_q;
	logic [F_W-1:0] lat_f_q;
	logic [G_W-1:0] lat_g_q;
	logic [PIN_W-1:0] sync1_q;
	logic [PIN_W-1:0] sync2_q;
	logic [PIN_W-1:0] sync3_q;
	logic [PIN_W-1:0] filt_q;
	logic [PIN_W-1:0] filt_d;

	// ==========================================================
	// Bus decode.
	wire [ADR_W-IDX_LSB-1:0] idx = adr_i[ADR_W-1:IDX_LSB];
	wire req = cyc_i & stb_i & ~ack_o;
	wire wr_lo = req & we_i & sel_i[0];
	wire rd = req & ~we_i;
	wire hit_de = idx == IDX_DATA_E;
	wire hit_df = idx == IDX_DATA_F;
	wire hit_dg = idx == IDX_DATA_G;
	wire hit_re = idx == IDX_DIR_E;
	wire hit_rf = idx == IDX_DIR_F;
	wire hit_rg = idx == IDX_DIR_G;

	// Filtered pin levels split per port.
	wire [E_W-1:0] lvl_e = filt_q[E_W-1:0];
	wire [F_W-1:0] lvl_f = filt_q[G_LSB-1:F_LSB];
	wire [G_W-1:0] lvl_g = filt_q[PIN_W-1:G_LSB];

	// Port data reads honour the direction bits even on borrowed pins.
	wire [7:0] rd_e = rd_mux(dir_e_q, lat_e_q, lvl_e);
	wire [7:0] rd_f = rd_mux({1'b0, dir_f_q}, {1'b0, lat_f_q}, {1'b0, lvl_f});
	wire [7:0] rd_g = rd_mux({5'h00, dir_g_q}, {5'h00, lat_g_q}, {5'h00, lvl_g});

	// Unmapped indices read zero; narrow ports read zero above their width.
	wire [7:0] rd_byte = hit_de ? rd_e :
		hit_df ? rd_f :
		hit_dg ? rd_g :
		hit_re ? dir_e_q :
		hit_rf ? {1'b0, dir_f_q} :
		hit_rg ? {5'h00, dir_g_q} : 8'h00;

	// ==========================================================
	// Pin ownership by the borrowing peripherals.
	wire [7:0] ta_own = els_owned({4'h0, timer_a_edge_level_select_bits_i});
	wire [7:0] tb_own = els_owned({12'h000, timer_b_edge_level_select_bits_i});
	wire spi_on = spi_enable_bit_i;
	wire spi_mst = spi_master_select_bit_i;
	// Slave select is free in master mode without mode-fault detection.
	wire ss_own = spi_on & ~(spi_mst & ~mode_fault_enable_bit_i);

	wire [E_W-1:0] own_e = {spi_on, spi_on, spi_on, ss_own, ta_own[1:0],
		serial_enable_bit_i, serial_enable_bit_i};
	wire [F_W-1:0] own_f = {1'b0, tb_own[1:0], ta_own[5:2]};
	wire [G_W-1:0] own_g = keyboard_irq_enable_bits_i;

	// Peripheral drive: master drives clock and MOSI, slave drives MISO.
	wire [E_W-1:0] per_oe_e = {spi_mst, spi_mst, ~spi_mst, 1'b0,
		timer_a_channel_pins_oe_i[1:0], 1'b0, 1'b1};
	wire [E_W-1:0] per_out_e = {spi_serial_clock_pin_i, spi_mosi_out_i, spi_miso_out_i,
		1'b0, timer_a_channel_pins_out_i[1:0], 1'b0, serial_txd_i};
	wire [F_W-1:0] per_oe_f = {1'b0, timer_b_channel_pins_oe_i, timer_a_channel_pins_oe_i[5:2]};
	wire [F_W-1:0] per_out_f = {1'b0, timer_b_channel_pins_out_i,
		timer_a_channel_pins_out_i[5:2]};

	// Owned pins ignore the direction bits; free pins follow them.
	wire [E_W-1:0] oe_e = (own_e & per_oe_e) | (~own_e & dir_e_q);
	wire [F_W-1:0] oe_f = (own_f & per_oe_f) | (~own_f & dir_f_q);
	wire [G_W-1:0] oe_g = ~own_g & dir_g_q;
	// An undriven pin shows zero so an uninitialised latch never reaches it.
	wire [E_W-1:0] out_e = oe_e & ((own_e & per_out_e) | (~own_e & lat_e_q));
	wire [F_W-1:0] out_f = oe_f & ((own_f & per_out_f) | (~own_f & lat_f_q));
	wire [G_W-1:0] out_g = oe_g & lat_g_q;

	// Per bit, the filtered level moves only when stages two and three agree.
	assign filt_d = (sync2_q & sync3_q) | (filt_q & (sync2_q ^ sync3_q));

	// ==========================================================
	// Direction registers; reset makes every pin an input.
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			dir_e_q <= DIR_RESET[E_W-1:0];
			dir_f_q <= DIR_RESET[F_W-1:0];
			dir_g_q <= DIR_RESET[G_W-1:0];
		end else begin
			if (wr_lo && hit_re) dir_e_q <= dat_i[E_W-1:0];
			if (wr_lo && hit_rf) dir_f_q <= dat_i[F_W-1:0];
			if (wr_lo && hit_rg) dir_g_q <= dat_i[G_W-1:0];
		end
	end

	// Data latches have no reset: reset keeps whatever software wrote.
	always_ff @(posedge clk_i) begin
		if (wr_lo && hit_de) lat_e_q <= dat_i[E_W-1:0];
		if (wr_lo && hit_df) lat_f_q <= dat_i[F_W-1:0];
		if (wr_lo && hit_dg) lat_g_q <= dat_i[G_W-1:0];
	end

	// Bus answer: one cycle after the request, dropped the next cycle.
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			ack_o <= 1'b0;
			dat_o <= '0;
		end else begin
			ack_o <= req;
			dat_o <= rd ? {24'h000000, rd_byte} : '0;
		end
	end

	// Pin input synchroniser and agreement filter.
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			sync1_q <= PIN_RESET;
			sync2_q <= PIN_RESET;
			sync3_q <= PIN_RESET;
			filt_q <= PIN_RESET;
		end else begin
			sync1_q <= {pin_g_i, pin_f_i, pin_e_i};
			sync2_q <= sync1_q;
			sync3_q <= sync2_q;
			filt_q <= filt_d;
		end
	end

	// Registered pin drive; this adds one cycle after a peripheral changes.
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			pin_e_oe_o <= '0;
			pin_f_oe_o <= '0;
			pin_g_oe_o <= '0;
			pin_e_o <= '0;
			pin_f_o <= '0;
			pin_g_o <= '0;
		end else begin
			pin_e_oe_o <= oe_e;
			pin_f_oe_o <= oe_f;
			pin_g_oe_o <= oe_g;
			pin_e_o <= out_e;
			pin_f_o <= out_f;
			pin_g_o <= out_g;
		end
	end

	assign pin_e_sync_o = lvl_e;
	assign pin_f_sync_o = lvl_f;
	assign pin_g_sync_o = lvl_g;

	// ==========================================================
	// Checks.
	logic [E_W-1:0] rd_e_h;
	logic [E_W-1:0] own_e_h;
	assign rd_e_h = rd_e;
	assign own_e_h = own_e;

	a_dir_reset: assert property (@(posedge clk_i) rst_i |=>
		(dir_e_q == '0 && dir_f_q == '0 && dir_g_q == '0))
		else $error("direction bits not cleared by reset");

	a_e_read_data: assert property (@(posedge clk_i) disable iff (rst_i)
		(rd && hit_de) |=> (ack_o && dat_o == {24'h000000, $past(rd_e_h)}))
		else $error("port E read value wrong");

	a_latch_write: assert property (@(posedge clk_i) disable iff (rst_i)
		(wr_lo && hit_de) |=> lat_e_q == $past(dat_i[7:0]))
		else $error("port E latch write lost");

	a_free_pin_dir: assert property (@(posedge clk_i) disable iff (rst_i)
		##1 (((pin_e_oe_o ^ $past(dir_e_q)) & ~$past(own_e_h)) == '0))
		else $error("free port E pin does not follow direction");

	a_spi_clock_dir: assert property (@(posedge clk_i) disable iff (rst_i)
		spi_enable_bit_i |=> pin_e_oe_o[E_SCK] == $past(spi_master_select_bit_i))
		else $error("SPI clock pin direction wrong");

	a_slave_sel_in: assert property (@(posedge clk_i) disable iff (rst_i)
		(spi_enable_bit_i && !spi_master_select_bit_i) |=> !pin_e_oe_o[E_SS])
		else $error("slave select pin driven in slave mode");

	a_serial_pins: assert property (@(posedge clk_i) disable iff (rst_i)
		serial_enable_bit_i |=> (pin_e_oe_o[E_TXD] && !pin_e_oe_o[E_RXD]
		&& pin_e_o[E_TXD] == $past(serial_txd_i)))
		else $error("serial pins not routed");

	a_kbd_override: assert property (@(posedge clk_i) disable iff (rst_i)
		##1 ((pin_g_oe_o & $past(keyboard_irq_enable_bits_i)) == '0))
		else $error("keyboard pin driven");

	a_single_ack: assert property (@(posedge clk_i) disable iff (rst_i)
		(req && hit_df) |=> (ack_o && dat_o[31:7] == '0) ##1 !ack_o)
		else $error("bus answer timing or upper bits wrong");

	a_e_pin_read: assert property (@(posedge clk_i) disable iff (rst_i)
		(rd && hit_de) |=> ((dat_o[7:0] ^ $past(lvl_e)) & ~$past(dir_e_q)) == '0)
		else $error("port E input bit did not read the pin");

	a_f_read_mix: assert property (@(posedge clk_i) disable iff (rst_i)
		(rd && hit_df) |=> ((((dat_o[6:0] ^ $past(lat_f_q)) & $past(dir_f_q))
		| ((dat_o[6:0] ^ $past(lvl_f)) & ~$past(dir_f_q))) == '0))
		else $error("port F read value wrong");

	a_g_read_mix: assert property (@(posedge clk_i) disable iff (rst_i)
		(rd && hit_dg) |=> (dat_o[31:3] == '0 && (((dat_o[2:0] ^ $past(lat_g_q))
		& $past(dir_g_q)) | ((dat_o[2:0] ^ $past(lvl_g)) & ~$past(dir_g_q))) == '0))
		else $error("port G read value wrong");

	a_unmapped_zero: assert property (@(posedge clk_i) disable iff (rst_i)
		(rd && !(hit_de || hit_df || hit_dg || hit_re || hit_rf || hit_rg)) |=> dat_o == '0)
		else $error("unmapped read not zero");

	a_ack_drop: assert property (@(posedge clk_i) disable iff (rst_i)
		ack_o |=> !ack_o)
		else $error("bus answer stood two cycles");

	a_idle_no_ack: assert property (@(posedge clk_i) disable iff (rst_i)
		!req |=> !ack_o)
		else $error("bus answer without request");

	a_dir_e_write: assert property (@(posedge clk_i) disable iff (rst_i)
		(wr_lo && hit_re) |=> dir_e_q == $past(dat_i[E_W-1:0]))
		else $error("port E direction write lost");

	a_dir_f_write: assert property (@(posedge clk_i) disable iff (rst_i)
		(wr_lo && hit_rf) |=> dir_f_q == $past(dat_i[F_W-1:0]))
		else $error("port F direction write lost");

	a_dir_g_write: assert property (@(posedge clk_i) disable iff (rst_i)
		(wr_lo && hit_rg) |=> dir_g_q == $past(dat_i[G_W-1:0]))
		else $error("port G direction write lost");

	a_spi_off_free: assert property (@(posedge clk_i) disable iff (rst_i)
		!spi_enable_bit_i |=> pin_e_oe_o[7:5] == $past(dir_e_q[7:5]))
		else $error("SPI pins not free while SPI is off");

	a_mosi_dir: assert property (@(posedge clk_i) disable iff (rst_i)
		spi_enable_bit_i |=> pin_e_oe_o[E_MOSI] == $past(spi_master_select_bit_i))
		else $error("MOSI pin direction wrong");

	a_miso_dir: assert property (@(posedge clk_i) disable iff (rst_i)
		spi_enable_bit_i |=> pin_e_oe_o[E_MISO] == !$past(spi_master_select_bit_i))
		else $error("MISO pin direction wrong");

	a_ss_free: assert property (@(posedge clk_i) disable iff (rst_i)
		(spi_enable_bit_i && spi_master_select_bit_i && !mode_fault_enable_bit_i)
		|=> pin_e_oe_o[E_SS] == $past(dir_e_q[E_SS]))
		else $error("free slave select pin ignores direction");

	a_serial_off: assert property (@(posedge clk_i) disable iff (rst_i)
		!serial_enable_bit_i |=> pin_e_oe_o[1:0] == $past(dir_e_q[1:0]))
		else $error("serial pins not free while serial is off");

	a_timer_f_free: assert property (@(posedge clk_i) disable iff (rst_i)
		(timer_a_edge_level_select_bits_i[5:4] == 2'h0)
		|=> pin_f_oe_o[0] == $past(dir_f_q[0]))
		else $error("free timer pin ignores direction");

	a_undriven_low: assert property (@(posedge clk_i) disable iff (rst_i)
		((pin_e_o & ~pin_e_oe_o) == '0 && (pin_f_o & ~pin_f_oe_o) == '0))
		else $error("released pin shows a drive value");

endmodule

`default_nettype wire

// ### src/spg_pkg.sv
// Constants for the shared-pin port E, F and G block: register indices,
// port widths, bus widths and the peripheral pin assignments.
// Assumes a 32-bit classic Wishbone slave with registers on word addresses.
//
// What this block does
// - Port E direction one drives the pin.
// - Reset clears all port E direction bits.
// - Port E read returns latch for outputs.
// - Port E read returns pin for inputs.
// - Data latch writes always land, input pins unaffected.
// - Bit E7 is SPI clock when enabled.
// - Bit E6 is SPI MOSI when enabled.
// - Bit E5 is SPI MISO when enabled.
// - Bit E4 slave select unless off or master without mode fault.
// - SPI slave ignores slave select direction bit.
// - Peripheral pins ignore direction, reads still use it.
// - E3, E2 follow timer A channel select.
// - E1 is serial receive when enabled.
// - E0 is serial transmit when enabled.
// - Seven port F direction bits, reset to input.
// - Port F read: latch out, pin in.
// - F3..F0 follow timer A channels 5..2.
// - F5, F4 follow timer B channels 1, 0.
// - Timer-owned F pins ignore direction bits.
// - Reset leaves data latches unchanged.
// - Keyboard enable overrides port G direction.
// - Three port G direction bits, reset input.
// - Port G read: latch out, pin in.

package spg_pkg;

	// ==========================================================
	// Register indices; the byte address is four times the index.
	localparam logic [5:0] IDX_DATA_E = 6'h08;
	localparam logic [5:0] IDX_DATA_F = 6'h09;
	localparam logic [5:0] IDX_DATA_G = 6'h0A;
	localparam logic [5:0] IDX_DIR_E = 6'h0C;
	localparam logic [5:0] IDX_DIR_F = 6'h0D;
	localparam logic [5:0] IDX_DIR_G = 6'h0E;

	// ==========================================================
	// Widths.
	localparam int DAT_W = 32;
	localparam int ADR_W = 8;
	localparam int IDX_LSB = 2;
	localparam int E_W = 8;
	localparam int F_W = 7;
	localparam int G_W = 3;
	localparam int PIN_W = E_W + F_W + G_W;
	localparam int TA_CH = 6;
	localparam int TB_CH = 2;

	// ==========================================================
	// Reset values and pin positions.
	localparam logic [7:0] DIR_RESET = 8'h00;
	localparam logic [PIN_W-1:0] PIN_RESET = 18'h00000;
	localparam int E_SCK = 7;
	localparam int E_MOSI = 6;
	localparam int E_MISO = 5;
	localparam int E_SS = 4;
	localparam int E_RXD = 1;
	localparam int E_TXD = 0;
	localparam int F_LSB = E_W;
	localparam int G_LSB = E_W + F_W;

endpackage

// ### testbench/spg_pin_env.sv
// Pad model for the outside world of one port.
// Assumes the outside drives every pad the block leaves released.
`timescale 1ns/1ps
`default_nettype none
// ==========================================================
// Pad resolution
module spg_pin_env #(
	parameter int W = 8
) (
	input wire logic [W-1:0] oe_i,
	input wire logic [W-1:0] out_i,
	input wire logic [W-1:0] ext_i,
	output logic [W-1:0] pad_o
);
	// A released pad follows the outside driver, so no pad ever floats.
	assign pad_o = (oe_i & out_i) | (~oe_i & ext_i);
endmodule
`default_nettype wire

// ### testbench/spg_gpio_tb.sv
// Self-checking bench for the shared-pin port block.
// Assumes the pad models of spg_pin_env sit on every port.
`timescale 1ns/1ps
`default_nettype none
module spg_gpio_tb;
	import spg_pkg::*;
	// ==========================================================
	// Signals
	logic clk_i = 0, rst_i = 1, cyc_i = 0, stb_i = 0, we_i = 0;
	logic [7:0] adr_i = 0;
	logic [3:0] sel_i = 0;
	logic [31:0] dat_i = 0, dat_o, rd;
	logic ack_o;
	logic [7:0] pin_e_i, pin_e_o, pin_e_oe_o, pin_e_sync_o, xe = 0, le, de;
	logic [6:0] pin_f_i, pin_f_o, pin_f_oe_o, pin_f_sync_o, xf = 0, lf, df;
	logic [2:0] pin_g_i, pin_g_o, pin_g_oe_o, pin_g_sync_o, xg = 0, lg, dg;
	logic spi_enable_bit_i = 0, spi_master_select_bit_i = 0, mode_fault_enable_bit_i = 0;
	logic spi_serial_clock_pin_i = 0, spi_mosi_out_i = 0, spi_miso_out_i = 0;
	logic serial_enable_bit_i = 0, serial_txd_i = 0;
	logic [11:0] timer_a_edge_level_select_bits_i = 0;
	logic [5:0] timer_a_channel_pins_out_i = 0, timer_a_channel_pins_oe_i = 0;
	logic [3:0] timer_b_edge_level_select_bits_i = 0;
	logic [1:0] timer_b_channel_pins_out_i = 0, timer_b_channel_pins_oe_i = 0;
	logic [2:0] keyboard_irq_enable_bits_i = 0;
	logic [15:0] ee;
	logic [13:0] ef;
	int failures = 0, checks = 0, cycles = 0;

	spg_gpio dut (.clk_i, .rst_i, .cyc_i, .stb_i, .we_i, .adr_i, .sel_i, .dat_i, .dat_o,
		.ack_o, .pin_e_i, .pin_e_o, .pin_e_oe_o, .pin_f_i, .pin_f_o, .pin_f_oe_o, .pin_g_i,
		.pin_g_o, .pin_g_oe_o, .pin_e_sync_o, .pin_f_sync_o, .pin_g_sync_o, .spi_enable_bit_i,
		.spi_master_select_bit_i, .mode_fault_enable_bit_i, .spi_serial_clock_pin_i,
		.spi_mosi_out_i, .spi_miso_out_i, .serial_enable_bit_i, .serial_txd_i,
		.timer_a_edge_level_select_bits_i, .timer_a_channel_pins_out_i,
		.timer_a_channel_pins_oe_i, .timer_b_edge_level_select_bits_i,
		.timer_b_channel_pins_out_i, .timer_b_channel_pins_oe_i, .keyboard_irq_enable_bits_i);
	spg_pin_env #(.W(8)) env_e (.oe_i(pin_e_oe_o), .out_i(pin_e_o), .ext_i(xe), .pad_o(pin_e_i));
	spg_pin_env #(.W(7)) env_f (.oe_i(pin_f_oe_o), .out_i(pin_f_o), .ext_i(xf), .pad_o(pin_f_i));
	spg_pin_env #(.W(3)) env_g (.oe_i(pin_g_oe_o), .out_i(pin_g_o), .ext_i(xg), .pad_o(pin_g_i));

	// ==========================================================
	// Clock and hang guard; the ceiling is far above the planned run.
	initial forever #20 clk_i = ~clk_i;
	always @(posedge clk_i) begin
		cycles++;
		if (cycles == 20000) begin
			failures++;
			test_done();
		end
	end

	// ==========================================================
	// Tasks
	task automatic test_done();
		$display("checks %0d failures %0d", checks, failures);
		if (failures == 0 && checks > 0) $display("TEST PASSED");
		else $display("TEST FAILED");
		$finish;
	endtask

	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		checks++;
		if (seen !== exp) begin
			failures++;
			$display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
		end
	endtask

	// One classic cycle; the request stands until the rising edge that samples ack high.
	task automatic bus(input logic w, input logic [5:0] idx, input logic [7:0] d);
		int n;
		n = 0;
		cyc_i <= 1;
		stb_i <= 1;
		we_i <= w;
		sel_i <= 4'hF;
		adr_i <= {idx, 2'h0};
		dat_i <= {24'h0, d};
		do begin
			@(posedge clk_i);
			n++;
		end while (ack_o !== 1'b1 && n < 16);
		chk(ack_o, 1);
		rd = dat_o;
		cyc_i <= 0;
		stb_i <= 0;
		@(posedge clk_i);
	endtask

	// Model of one port: drive, filtered level and both read-backs.
	task automatic port_chk(input logic [7:0] oe, ov, sy, eoe, eov, ext, lat, dir,
		input logic [5:0] idx);
		logic [7:0] pad;
		pad = (eoe & eov) | (~eoe & ext);
		chk(oe, eoe);
		chk(ov, eov);
		chk(sy, pad);
		bus(0, idx, 0);
		chk(rd, {24'h0, (dir & lat) | (~dir & pad)});
		bus(0, idx + 6'h04, 0);
		chk(rd, {24'h0, dir});
	endtask

	function automatic logic [15:0] exp_e();
		logic [7:0] oe, ov;
		oe = de;
		ov = le;
		if (spi_enable_bit_i) begin
			{oe[7], oe[6], oe[5]} = {{2{spi_master_select_bit_i}}, !spi_master_select_bit_i};
			{ov[7], ov[6], ov[5]} = {spi_serial_clock_pin_i, spi_mosi_out_i, spi_miso_out_i};
			if (!(spi_master_select_bit_i && !mode_fault_enable_bit_i)) oe[4] = 0;
		end
		for (int i = 0; i < 2; i++) if (timer_a_edge_level_select_bits_i[2*i+:2] != 0) begin
			oe[2+i] = timer_a_channel_pins_oe_i[i];
			ov[2+i] = timer_a_channel_pins_out_i[i];
		end
		if (serial_enable_bit_i) begin
			{oe[1], oe[0], ov[0]} = {2'h1, serial_txd_i};
		end
		return {oe, oe & ov};
	endfunction

	function automatic logic [13:0] exp_f();
		logic [6:0] oe, ov;
		oe = df;
		ov = lf;
		for (int i = 0; i < 4; i++) if (timer_a_edge_level_select_bits_i[2*i+4+:2] != 0) begin
			oe[i] = timer_a_channel_pins_oe_i[i+2];
			ov[i] = timer_a_channel_pins_out_i[i+2];
		end
		for (int j = 0; j < 2; j++) if (timer_b_edge_level_select_bits_i[2*j+:2] != 0) begin
			oe[4+j] = timer_b_channel_pins_oe_i[j];
			ov[4+j] = timer_b_channel_pins_out_i[j];
		end
		return {oe, oe & ov};
	endfunction

	task automatic all_chk();
		ee = exp_e();
		ef = exp_f();
		port_chk(pin_e_oe_o, pin_e_o, pin_e_sync_o, ee[15:8], ee[7:0], xe, le, de, IDX_DATA_E);
		port_chk(pin_f_oe_o, pin_f_o, pin_f_sync_o, ef[13:7], ef[6:0], xf, lf, df, IDX_DATA_F);
		port_chk(pin_g_oe_o, pin_g_o, pin_g_sync_o, dg & ~keyboard_irq_enable_bits_i,
			dg & ~keyboard_irq_enable_bits_i & lg, xg, lg, dg, IDX_DATA_G);
	endtask

	// ==========================================================
	// Main sequence
	initial begin
		void'($urandom(17));
		repeat (8) @(posedge clk_i);
		rst_i <= 0;
		for (int t = 0; t < 41; t++) begin
			if (t == 40) begin
				// Second reset with peripherals off; latches must survive it.
				{spi_enable_bit_i, serial_enable_bit_i, keyboard_irq_enable_bits_i} <= 0;
				timer_a_edge_level_select_bits_i <= 0;
				timer_b_edge_level_select_bits_i <= 0;
				rst_i <= 1;
				repeat (2) @(posedge clk_i);
				rst_i <= 0;
				{de, df, dg} = 18'h3FFFF;
			end else begin
				{le, lf, lg, de, df, dg} = 36'({$urandom, $urandom});
				{xe, xf, xg} <= 18'($urandom);
				{spi_enable_bit_i, spi_master_select_bit_i, mode_fault_enable_bit_i,
					spi_serial_clock_pin_i, spi_mosi_out_i, spi_miso_out_i,
					serial_enable_bit_i, serial_txd_i} <= 8'($urandom);
				{timer_a_edge_level_select_bits_i, timer_a_channel_pins_out_i,
					timer_a_channel_pins_oe_i} <= 24'($urandom);
				{timer_b_edge_level_select_bits_i, timer_b_channel_pins_out_i,
					timer_b_channel_pins_oe_i, keyboard_irq_enable_bits_i} <= 11'($urandom);
				bus(1, IDX_DATA_E, le);
				bus(1, IDX_DATA_F, {1'b0, lf});
				bus(1, IDX_DATA_G, {5'h0, lg});
				bus(1, 6'h20, 8'($urandom));
				bus(0, 6'h3F, 0);
				chk(rd, 0);
			end
			for (int r = 0; r < 3; r++) begin
				bus(0, IDX_DIR_E + 6'(r), 0);
				if (t == 0 || t == 40) chk(rd, 0);
			end
			bus(1, IDX_DIR_E, de);
			bus(1, IDX_DIR_F, {1'b0, df});
			bus(1, IDX_DIR_G, {5'h0, dg});
			repeat (8) @(posedge clk_i);
			all_chk();
		end
		$display("random and reset tests done");
		test_done();
	end
endmodule
`default_nettype wire
